/* rtl/ads_pkg.sv */
package ads_pkg;

  // Clock and symbol timing
  localparam int CLK_NS = 8;
  localparam int SYM_NS = 4;
  localparam int SYM_PER_CLK = CLK_NS / SYM_NS;

  // Link figures
  localparam int LANE_MBPS = 2500;
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X2 = 2'h1;
  localparam logic [1:0] WIDTH_X4 = 2'h2;

  // Default acknowledgement reloads, in symbol times
  localparam logic [11:0] ACK_RELOAD_X1 = 12'h0ff;
  localparam logic [11:0] ACK_RELOAD_X2 = 12'h0d9;
  localparam logic [11:0] ACK_RELOAD_X4 = 12'h076;

  // Pending-TLP trigger
  localparam logic [3:0] ACK_TLP_LIMIT = 4'hc;

  // Replay storage depth per port
  localparam int REPLAY_LOW_PORTS_MAX = 2;
  localparam logic [6:0] REPLAY_DEPTH_LOW = 7'h40;
  localparam logic [6:0] REPLAY_DEPTH_HIGH = 7'h20;

  // SKIP ordered set spacing and length
  localparam int SKIP_SYM = 1100;
  localparam int SKIP_CYC = SKIP_SYM * SYM_NS / CLK_NS;
  localparam int SKIP_LEN_SYM = 4;
  localparam int SKIP_LEN_CYC = (SKIP_LEN_SYM * SYM_NS + CLK_NS - 1) / CLK_NS;

  // Periodic ACK and flow-control refresh
  localparam int PERIOD_US = 30;
  localparam int PERIOD_CYC = PERIOD_US * 1000 / CLK_NS;

  // Register map, byte addresses
  localparam logic [11:0] OFS_LAT_LIMIT = 12'h1f8;
  localparam logic [11:0] OFS_CTRL = 12'h1fc;
  localparam logic [11:0] OFS_STATUS = 12'h200;

  // Latency limit field
  localparam int LAT_LSB = 0;
  localparam int LAT_W = 12;
  localparam logic [11:0] LAT_RST = 12'h000;

  // Control fields
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_OPP_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status fields
  localparam int ST_PEND_LSB = 0;
  localparam int ST_TMR_ACT_BIT = 4;
  localparam int ST_FULL_BIT = 5;
  localparam int ST_REPLAY_LSB = 8;
  localparam int ST_TMR_LSB = 16;

endpackage

/* rtl/ads_down_cnt.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Saturating down counter with load and clear
module ads_down_cnt #(
  parameter int W = 12,
  parameter logic [W-1:0] STEP = W'(1),
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic clear,
  output logic [W-1:0] cnt,
  output logic zero
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Load first, then clear, else step toward zero
  always_comb begin
    if (load) begin
      cnt_nxt = load_val;
    end else if (clear) begin
      cnt_nxt = '0;
    end else if (cnt_r > STEP) begin
      cnt_nxt = cnt_r - STEP;
    end else begin
      cnt_nxt = '0;
    end
  end

  // Count register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt = cnt_r;
  assign zero = (cnt_r == '0);

endmodule

`default_nettype wire

/* rtl/ads_ack_sched.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Link is x1, x2 or x4 at 2500 Mbps
// - Good received TLP reloads acknowledgement timer
// - Default reload 255, 217, 118 by width
// - Timer counts down each 4 ns symbol
// - Expired timer: finish TLP, then ACK first
// - ACK carries newest good received sequence
// - Twelve pending TLPs raise high-priority ACK
// - Idle transmitter may send early low-priority ACK
// - Any ACK stops timer until next TLP
// - Latency limit register overrides reload value
// - Limit zero gives one ACK per TLP
// - Replay holds 64 or 32 TLPs by port
// - TLPs win; promoted DLLP never splits TLP
// - SKIP every 1100 symbols, four symbols long
module ads_ack_sched #(
  parameter int PORT_NUM = 0
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [1:0] LINK_WIDTH,
  input wire logic RX_TLP_GOOD,
  input wire logic [11:0] RX_TLP_SEQ,
  input wire logic TX_TLP_REQ,
  input wire logic TX_TLP_BUSY,
  input wire logic TX_TLP_SENT,
  input wire logic TX_TLP_FREED,
  output logic TX_TLP_HOLD,
  output logic TX_ACK_SEND,
  output logic TX_ACK_HIPRI,
  output logic [11:0] TX_ACK_SEQ,
  output logic TX_FC_UPDATE,
  output logic TX_SKIP,
  output logic TX_REPLAY_FULL
);
  import ads_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register file state
  logic [11:0] lat_r;
  logic [11:0] lat_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Scheduler state
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic tmr_act_r;
  logic tmr_act_nxt;
  logic [11:0] seq_r;
  logic [11:0] seq_nxt;
  logic per_due_r;
  logic per_due_nxt;
  logic skip_due_r;
  logic skip_due_nxt;
  logic [1:0] skip_left_r;
  logic [1:0] skip_left_nxt;
  logic [6:0] replay_r;
  logic [6:0] replay_nxt;

  // Output registers
  logic ack_send_r;
  logic ack_send_nxt;
  logic ack_hipri_r;
  logic ack_hipri_nxt;
  logic [11:0] ack_seq_r;
  logic [11:0] ack_seq_nxt;
  logic fc_upd_r;
  logic fc_upd_nxt;
  logic hold_r;
  logic hold_nxt;
  logic skip_r;
  logic skip_nxt;
  logic full_r;
  logic full_nxt;

  // Counter taps and decisions
  logic [11:0] tmr_cnt;
  logic tmr_zero;
  logic [11:0] tmr_load_val;
  logic [11:0] skip_cnt;
  logic skip_zero;
  logic [11:0] per_cnt;
  logic per_zero;
  logic [11:0] width_reload;
  logic [6:0] replay_depth;
  logic hi_due;
  logic lo_ok;
  logic skip_start;
  logic ack_fire;

  ////////////////////////////////////////////////////////////////////////
  // Reload value chosen by negotiated width or by the override
  always_comb begin
    case (LINK_WIDTH)
      WIDTH_X1: width_reload = ACK_RELOAD_X1;
      WIDTH_X2: width_reload = ACK_RELOAD_X2;
      WIDTH_X4: width_reload = ACK_RELOAD_X4;
      default: width_reload = ACK_RELOAD_X1;
    endcase
    tmr_load_val = ctrl_r[CTRL_OVR_BIT] ? lat_r : width_reload;
  end

  // Acknowledgement timer, two symbol times per clock
  ads_down_cnt #(
    .W(12),
    .STEP(12'(SYM_PER_CLK)),
    .RST_VAL(12'h000)
  ) u_ack_tmr (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .load(RX_TLP_GOOD),
    .load_val(tmr_load_val),
    .clear(ack_fire),
    .cnt(tmr_cnt),
    .zero(tmr_zero)
  );

  // SKIP interval, reloads itself at each expiry
  ads_down_cnt #(
    .W(12),
    .STEP(12'h001),
    .RST_VAL(12'(SKIP_CYC - 1))
  ) u_skip_tmr (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .load(skip_zero),
    .load_val(12'(SKIP_CYC - 1)),
    .clear(1'b0),
    .cnt(skip_cnt),
    .zero(skip_zero)
  );

  // Refresh interval, restarted by every ACK
  ads_down_cnt #(
    .W(12),
    .STEP(12'h001),
    .RST_VAL(12'(PERIOD_CYC - 1))
  ) u_per_tmr (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .load(ack_fire),
    .load_val(12'(PERIOD_CYC - 1)),
    .clear(1'b0),
    .cnt(per_cnt),
    .zero(per_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // Arbitration between TLPs, SKIP and ACK
  always_comb begin
    // Replay depth is fixed by the port's place in the switch
    replay_depth = (PORT_NUM <= REPLAY_LOW_PORTS_MAX) ? REPLAY_DEPTH_LOW : REPLAY_DEPTH_HIGH;
    // High priority: expired timer, twelve pending, or refresh due
    hi_due = (tmr_act_r && tmr_zero)
      || (pend_r >= ACK_TLP_LIMIT)
      || per_due_r;
    // Low priority only with nothing queued to send
    lo_ok = ctrl_r[CTRL_OPP_BIT] && (pend_r != 4'h0) && !TX_TLP_REQ;
    // SKIP goes out between TLPs and ahead of an ACK
    skip_start = (skip_due_r || skip_zero) && !TX_TLP_BUSY && (skip_left_r == 2'h0) && !ack_send_r;
    ack_fire = (hi_due || lo_ok) && !TX_TLP_BUSY && !skip_start
      && (skip_left_r == 2'h0) && !ack_send_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending count, timer activity, sequence and due flags
  always_comb begin
    pend_nxt = pend_r;
    tmr_act_nxt = tmr_act_r;
    seq_nxt = seq_r;
    per_due_nxt = per_due_r;
    skip_due_nxt = skip_due_r;
    skip_left_nxt = skip_left_r;
    replay_nxt = replay_r;
    // An ACK empties the pending count and parks the timer
    if (ack_fire) begin
      pend_nxt = 4'h0;
      tmr_act_nxt = 1'b0;
      per_due_nxt = 1'b0;
    end
    if (RX_TLP_GOOD) begin
      // A TLP in the ACK cycle stays pending for the next ACK
      seq_nxt = RX_TLP_SEQ;
      tmr_act_nxt = 1'b1;
      if (ack_fire) begin
        pend_nxt = 4'h1;
      end else if (pend_r < ACK_TLP_LIMIT) begin
        pend_nxt = pend_r + 4'h1;
      end
    end
    // Refresh falls due at expiry unless an ACK leaves now
    if (per_zero && !ack_fire) begin
      per_due_nxt = 1'b1;
    end
    // A SKIP start clears its due flag and arms its length
    if (skip_start) begin
      skip_due_nxt = 1'b0;
      skip_left_nxt = 2'(SKIP_LEN_CYC);
    end else begin
      if (skip_zero) begin
        skip_due_nxt = 1'b1;
      end
      if (skip_left_r != 2'h0) begin
        skip_left_nxt = skip_left_r - 2'h1;
      end
    end
    // Replay occupancy, sent minus released
    if (TX_TLP_SENT && !TX_TLP_FREED && replay_r < replay_depth) begin
      replay_nxt = replay_r + 7'h01;
    end else if (TX_TLP_FREED && !TX_TLP_SENT && replay_r != 7'h00) begin
      replay_nxt = replay_r - 7'h01;
    end
  end

  // Scheduler registers, cleared by the synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pend_r <= 4'h0;
      tmr_act_r <= 1'b0;
      seq_r <= 12'h000;
      per_due_r <= 1'b0;
      skip_due_r <= 1'b0;
      skip_left_r <= 2'h0;
      replay_r <= 7'h00;
    end else begin
      pend_r <= pend_nxt;
      tmr_act_r <= tmr_act_nxt;
      seq_r <= seq_nxt;
      per_due_r <= per_due_nxt;
      skip_due_r <= skip_due_nxt;
      skip_left_r <= skip_left_nxt;
      replay_r <= replay_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit-side outputs
  always_comb begin
    // Launched one cycle after the decision, so ACK fields line up
    ack_send_nxt = ack_fire;
    ack_hipri_nxt = ack_fire && hi_due;
    ack_seq_nxt = ack_fire ? seq_r : ack_seq_r;
    fc_upd_nxt = ack_fire && per_due_r;
    skip_nxt = skip_start || (skip_left_r > 2'h1);
    full_nxt = (replay_nxt >= replay_depth);
    // Holding new TLPs lets a promoted DLLP or SKIP go next
    hold_nxt = (hi_due && !ack_fire) || (skip_due_r && !skip_start) || skip_nxt || full_nxt;
  end

  // Output flops, so every port comes from a register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ack_send_r <= 1'b0;
      ack_hipri_r <= 1'b0;
      ack_seq_r <= 12'h000;
      fc_upd_r <= 1'b0;
      skip_r <= 1'b0;
      full_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      ack_send_r <= ack_send_nxt;
      ack_hipri_r <= ack_hipri_nxt;
      ack_seq_r <= ack_seq_nxt;
      fc_upd_r <= fc_upd_nxt;
      skip_r <= skip_nxt;
      full_r <= full_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Ports driven straight from the output flops
  assign TX_ACK_SEND = ack_send_r;
  assign TX_ACK_HIPRI = ack_hipri_r;
  assign TX_ACK_SEQ = ack_seq_r;
  assign TX_FC_UPDATE = fc_upd_r;
  assign TX_SKIP = skip_r;
  assign TX_REPLAY_FULL = full_r;
  assign TX_TLP_HOLD = hold_r;

  ////////////////////////////////////////////////////////////////////////
  // Register writes and one-cycle-late reads
  always_comb begin
    lat_nxt = lat_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = 32'h0000_0000;
    if (REG_WR) begin
      if (REG_ADDR == OFS_LAT_LIMIT) begin
        lat_nxt = REG_WDATA[LAT_LSB +: LAT_W];
      end
      if (REG_ADDR == OFS_CTRL) begin
        ctrl_nxt = REG_WDATA[1:0];
      end
    end
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_LAT_LIMIT: rdata_nxt[LAT_LSB +: LAT_W] = lat_r;
        OFS_CTRL: rdata_nxt[1:0] = ctrl_r;
        OFS_STATUS: begin
          rdata_nxt[ST_PEND_LSB +: 4] = pend_r;
          rdata_nxt[ST_TMR_ACT_BIT] = tmr_act_r;
          rdata_nxt[ST_FULL_BIT] = full_r;
          rdata_nxt[ST_REPLAY_LSB +: 7] = replay_r;
          rdata_nxt[ST_TMR_LSB +: 12] = tmr_cnt;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file and read-data flops
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lat_r <= LAT_RST;
      ctrl_r <= CTRL_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      lat_r <= lat_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Read data stand one cycle, then fall back to zero
  assign REG_RDATA = rdata_r;

endmodule

`default_nettype wire

/* verif/ads_ack_sched_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Port checks for the ACK scheduler
module ads_ack_checker
  import ads_pkg::*;
#(
  parameter int PORT_NUM = 0
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic RX_TLP_GOOD,
  input wire logic [11:0] RX_TLP_SEQ,
  input wire logic TX_TLP_SENT,
  input wire logic TX_TLP_FREED,
  input wire logic TX_TLP_HOLD,
  input wire logic TX_ACK_SEND,
  input wire logic TX_ACK_HIPRI,
  input wire logic [11:0] TX_ACK_SEQ,
  input wire logic TX_FC_UPDATE,
  input wire logic TX_SKIP,
  input wire logic TX_REPLAY_FULL
);
  localparam logic [7:0] DEPTH = (PORT_NUM <= REPLAY_LOW_PORTS_MAX) ? 8'h40 : 8'h20;
  logic [11:0] seq_r, seq_nxt, sgap_r, sgap_nxt;
  logic [12:0] agap_r, agap_nxt;
  logic [7:0] occ_r, occ_nxt;

  // Newest good sequence, replay occupancy and gap counters
  always_comb begin
    seq_nxt = RX_TLP_GOOD ? RX_TLP_SEQ : seq_r;
    occ_nxt = occ_r + 8'(TX_TLP_SENT) - 8'(TX_TLP_FREED);
    sgap_nxt = TX_SKIP ? 12'h000 : sgap_r + 12'h001;
    agap_nxt = TX_ACK_SEND ? 13'h0000 : agap_r + 13'h0001;
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      seq_r <= 12'h000;
      occ_r <= 8'h00;
      sgap_r <= 12'h000;
      agap_r <= 13'h0000;
    end else begin
      seq_r <= seq_nxt;
      occ_r <= occ_nxt;
      sgap_r <= sgap_nxt;
      agap_r <= agap_nxt;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  a_ack_single: assert property (TX_ACK_SEND |=> !TX_ACK_SEND)
    else $error("ACK pulse longer than one cycle");
  a_hipri_ack: assert property (TX_ACK_HIPRI |-> TX_ACK_SEND)
    else $error("priority flag without ACK");
  a_ack_seq: assert property (TX_ACK_SEND |-> TX_ACK_SEQ == $past(seq_r))
    else $error("ACK carries wrong sequence");
  a_fc_ack: assert property (TX_FC_UPDATE |-> TX_ACK_SEND)
    else $error("flow update without ACK");
  a_ack_skip: assert property (TX_ACK_SEND |-> !TX_SKIP)
    else $error("ACK during SKIP");
  a_skip_len: assert property ($rose(TX_SKIP) |-> TX_TLP_HOLD ##1 TX_SKIP ##1 !TX_SKIP)
    else $error("SKIP length or hold wrong");
  a_skip_gap: assert property (sgap_r <= SKIP_CYC + 32)
    else $error("SKIP spacing too long");
  a_refresh_gap: assert property (agap_r <= PERIOD_CYC + 32)
    else $error("periodic ACK missing");
  a_replay_full: assert property ((occ_r >= DEPTH) [*3] |-> TX_REPLAY_FULL && TX_TLP_HOLD)
    else $error("replay full not flagged");
  a_replay_room: assert property ((occ_r < DEPTH) [*3] |-> !TX_REPLAY_FULL)
    else $error("replay full too early");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside read slot");

  c_hipri: cover property (TX_ACK_SEND && TX_ACK_HIPRI);
  c_lopri: cover property (TX_ACK_SEND && !TX_ACK_HIPRI);
  c_skip: cover property ($rose(TX_SKIP));
  c_full: cover property (TX_REPLAY_FULL);
endmodule

bind ads_ack_sched ads_ack_checker #(.PORT_NUM(PORT_NUM)) u_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .RX_TLP_GOOD(RX_TLP_GOOD), .RX_TLP_SEQ(RX_TLP_SEQ), .TX_TLP_SENT(TX_TLP_SENT),
  .TX_TLP_FREED(TX_TLP_FREED), .TX_TLP_HOLD(TX_TLP_HOLD), .TX_ACK_SEND(TX_ACK_SEND),
  .TX_ACK_HIPRI(TX_ACK_HIPRI), .TX_ACK_SEQ(TX_ACK_SEQ), .TX_FC_UPDATE(TX_FC_UPDATE),
  .TX_SKIP(TX_SKIP), .TX_REPLAY_FULL(TX_REPLAY_FULL)
);
`default_nettype wire

/* verif/ads_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Far port: sends bursts of good TLPs on command
module ads_link_partner (
  input wire logic clk,
  input wire logic start,
  input wire logic [4:0] count,
  input wire logic [1:0] gap,
  input wire logic [11:0] first,
  output logic good,
  output logic [11:0] seq
);
  // Sequence numbers count up and wrap; data is inverted when idle
  initial begin
    good = 1'b0;
    seq = 12'h000;
    forever begin
      @(posedge clk);
      if (start) begin
        for (int i = 0; i < count; i++) begin
          good <= 1'b1;
          seq <= first + 12'(i);
          @(posedge clk);
          if (gap != 2'h0 || i == count - 1) begin
            good <= 1'b0;
            seq <= ~seq;
            repeat (gap) @(posedge clk);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verif/ads_ack_sched_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ads_ack_sched_bench;
  import ads_pkg::*;
  logic clk, rst_n, wr, rd, good, busy, req, sent, freed, go, hold, ack, hi, fc, skip, full;
  logic [11:0] addr, seq, first, aseq;
  logic [31:0] wdata, rdata, d;
  logic [1:0] width, gp;
  logic [4:0] cnt;
  logic [13:0] ackq[$];
  int err_total, total_checks, lat, nxt_seq, skip_base;
  int cyc = 0;
  int skip_cyc = 0;
  int rel[4] = '{255, 217, 118, 255};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ads_ack_sched #(.PORT_NUM(0)) u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .LINK_WIDTH(width), .RX_TLP_GOOD(good), .RX_TLP_SEQ(seq), .TX_TLP_REQ(req),
    .TX_TLP_BUSY(busy), .TX_TLP_SENT(sent), .TX_TLP_FREED(freed), .TX_TLP_HOLD(hold),
    .TX_ACK_SEND(ack), .TX_ACK_HIPRI(hi), .TX_ACK_SEQ(aseq), .TX_FC_UPDATE(fc), .TX_SKIP(skip),
    .TX_REPLAY_FULL(full)
  );
  ads_link_partner u_lp (.clk(clk), .start(go), .count(cnt), .gap(gp), .first(first), .good(good), .seq(seq));

  ////////////////////////////////////////
  // ACK monitor and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ack === 1'b1) ackq.push_back({fc, hi, aseq});
    if (skip === 1'b1) skip_cyc <= skip_cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [11:0] a, logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [11:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // Burst of n TLPs from the far port, returns once the last is taken
  task automatic send(int n, logic [1:0] g);
    logic [11:0] f;
    f = 12'($urandom);
    nxt_seq = (f + n - 1) % 4096;
    @(posedge clk);
    first <= f;
    cnt <= 5'(n);
    gp <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n * (g + 1)) @(posedge clk);
  endtask
  // Looks just after each edge, once the monitor has pushed
  task automatic get_ack(int mx, logic h, logic f);
    logic [13:0] a;
    lat = 0;
    while (ackq.size() == 0 && lat < mx) begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk("ack seen", 1, ackq.size() != 0);
    if (ackq.size() != 0) begin
      a = ackq.pop_front();
      chk("hipri", h, a[12]);
      chk("fc update", f, a[13]);
      chk("ack seq", nxt_seq, a[11:0]);
    end
  endtask
  task automatic no_ack(int n);
    repeat (n) @(posedge clk);
    #1 chk("no ack", 0, ackq.size());
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    {rst_n, wr, rd, busy, req, sent, freed, go} = 8'h00;
    {addr, wdata, width, first, cnt, gp} = '0;
    err_total = 0;
    total_checks = 0;
    d = $urandom(81856);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, field width
    rd_chk(OFS_LAT_LIMIT, 32'(LAT_RST));
    rd_chk(OFS_CTRL, 32'(CTRL_RST));
    wr_reg(12'h0f0, 32'hffffffff);
    rd_chk(12'h0f0, 32'h0);
    d = $urandom;
    wr_reg(OFS_LAT_LIMIT, d);
    rd_chk(OFS_LAT_LIMIT, d & 32'hfff);
    $display("registers done");
    // Width defaults, timer expiry
    wr_reg(OFS_CTRL, 32'h0);
    foreach (rel[i]) begin
      width <= 2'(i);
      ackq.delete();
      send(1, 2'h0);
      get_ack(400, 1'b1, 1'b0);
      chk("latency", 1, lat >= rel[i] / 2 && lat <= rel[i] / 2 + 8);
    end
    no_ack(300);
    $display("width defaults done");
    // Zero limit: one ACK per TLP
    wr_reg(OFS_LAT_LIMIT, 32'h0);
    wr_reg(OFS_CTRL, 32'h1);
    repeat (3) begin
      send(1, 2'h0);
      get_ack(8, 1'b1, 1'b0);
    end
    // Smallest limit that software is told to use
    wr_reg(OFS_LAT_LIMIT, 32'h1);
    send(1, 2'h0);
    get_ack(8, 1'b1, 1'b0);
    // Twelve-TLP trigger with a long limit
    wr_reg(OFS_LAT_LIMIT, 32'hfff);
    send(11, 2'($urandom));
    no_ack(60);
    send(1, 2'h0);
    get_ack(10, 1'b1, 1'b0);
    $display("limit and counter done");
    // Opportunistic ACK only when transmit is idle
    wr_reg(OFS_CTRL, 32'h3);
    @(posedge clk);
    req <= 1'b1;
    send(1, 2'h0);
    no_ack(40);
    @(posedge clk);
    req <= 1'b0;
    get_ack(10, 1'b0, 1'b0);
    // Expired timer waits for the TLP on the wire
    wr_reg(OFS_CTRL, 32'h1);
    wr_reg(OFS_LAT_LIMIT, 32'h0);
    @(posedge clk);
    busy <= 1'b1;
    send(1, 2'h0);
    no_ack(20);
    #1 chk("hold", 1, hold);
    @(posedge clk);
    busy <= 1'b0;
    get_ack(6, 1'b1, 1'b0);
    no_ack(50);
    $display("priority done");
    // Replay storage depth
    for (int i = 1; i <= 64; i++) begin
      @(posedge clk);
      sent <= 1'b1;
      @(posedge clk);
      sent <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("full", i == 64, full);
    end
    @(posedge clk);
    freed <= 1'b1;
    @(posedge clk);
    freed <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("full", 0, full);
    rd_chk(OFS_STATUS, 32'(63) << ST_REPLAY_LSB);
    $display("replay done");
    // Periodic refresh with nothing pending, SKIPs meanwhile
    skip_base = skip_cyc;
    get_ack(PERIOD_CYC + 40, 1'b1, 1'b1);
    chk("refresh", 1, lat >= PERIOD_CYC - 400 && lat <= PERIOD_CYC + 8);
    skip_base = skip_cyc - skip_base;
    chk("skip cycles", 1, skip_base >= 2 * (lat / SKIP_CYC) - 1 && skip_base <= 2 * (lat / SKIP_CYC) + 3);
    $display("refresh done");
    close_out();
  end
endmodule
`default_nettype wire
